// [dfsl_top.sv]
/*
 * Data-side fault status log with an AXI4-Lite register slave.
 * Assumes one fault report per cycle from the translation pipeline, on aclk.
 */
`timescale 1ns/1ps
`include "dfsl_map.svh"


module dfsl_top
    import dfsl_pkg::*;
(
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire dfsl_fault_t   fault,
    input  wire logic [7:0]    s_axi_awaddr,
    input  wire logic [2:0]    s_axi_awprot,
    input  wire logic          s_axi_awvalid,
    output logic               s_axi_awready,
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output logic               s_axi_wready,
    output logic [1:0]         s_axi_bresp,
    output logic               s_axi_bvalid,
    input  wire logic          s_axi_bready,
    input  wire logic [7:0]    s_axi_araddr,
    input  wire logic [2:0]    s_axi_arprot,
    input  wire logic          s_axi_arvalid,
    output logic               s_axi_arready,
    output logic [31:0]        s_axi_rdata,
    output logic [1:0]         s_axi_rresp,
    output logic               s_axi_rvalid,
    input  wire logic          s_axi_rready,
    output logic [63:0]        data_fault_status
);

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    dfsl_state_t st_r;
    dfsl_state_t st_nxt;

    // ------------------------------------------------------------------
    // Implicit address space identifier
    // ------------------------------------------------------------------
    function automatic logic [7:0] implicit_asi(input logic lvl_nz,
                                                input logic le);
        logic [7:0] v;
        v = 8'h00;
        if (!lvl_nz && !le) begin
            v = `DFSL_ASI_PRIMARY;
        end else if (!lvl_nz) begin
            v = `DFSL_ASI_PRIMARY_LE;
        end else if (!le) begin
            v = `DFSL_ASI_NUCLEUS;
        end else begin
            v = `DFSL_ASI_NUCLEUS_LE;
        end
        return v;
    endfunction : implicit_asi

    // Byte-lane merge of a 32-bit write.
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
        logic [31:0] m;
        m = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                m[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return m;
    endfunction : lane_merge

    // ------------------------------------------------------------------
    // Fault record capture
    // ------------------------------------------------------------------
    logic [63:0] rec;
    logic [7:0]  asi_used;
    logic        any_buf_err;
    logic        io_err;

    always_comb begin
        rec         = st_r.status;
        asi_used    = fault.asi_explicit ? fault.asi
                      : implicit_asi(fault.trap_level_nz,
                                     fault.current_little_endian);
        any_buf_err = fault.first_parity | fault.second_parity |
                      fault.second_multihit | fault.first_multihit;
        io_err      = fault.uncorrectable | fault.bus_error |
                      fault.bus_timeout;
        if (fault.kind == DFSL_EV_MISS) begin
            rec[`DFSL_MISS_BIT] = 1'b1;
            if (!st_r.status[`DFSL_VALID_BIT]) begin
                rec[`DFSL_ASI_HI:`DFSL_ASI_LO] = asi_used;
                rec[`DFSL_CTX_HI:`DFSL_CTX_LO] = fault.context_type;
            end
        end else if (fault.kind != DFSL_EV_NONE) begin
            rec[`DFSL_OVWR_BIT]  = st_r.status[`DFSL_VALID_BIT];
            rec[`DFSL_VALID_BIT] = 1'b1;
            rec[`DFSL_MISS_BIT]  = 1'b0;
            rec[`DFSL_ASI_HI:`DFSL_ASI_LO] = asi_used;
            rec[`DFSL_CTX_HI:`DFSL_CTX_LO] = fault.context_type;
            rec[`DFSL_NOTRAP_BIT] = fault.no_trap_load;
            if (fault.kind == DFSL_EV_EXC) begin
                rec[`DFSL_FTYPE_HI:`DFSL_FTYPE_LO] =
                    fault.fault_type_code;
            end else begin
                rec[`DFSL_UNCORR_BIT] = fault.uncorrectable;
                rec[`DFSL_MARK_BIT]   = fault.uncorrectable;
                rec[`DFSL_MARKID_HI:`DFSL_MARKID_LO] = fault.mark_id;
                rec[`DFSL_BUSERR_BIT] = fault.bus_error;
                rec[`DFSL_BUSTMO_BIT] = fault.bus_timeout;
                rec[`DFSL_NC_BIT]     = io_err & fault.noncacheable;
                rec[`DFSL_E_BIT]    = io_err &
                    (fault.side_effect_page |
                     asi_used == `DFSL_ASI_SIDE_A |
                     asi_used == `DFSL_ASI_SIDE_B);
                rec[`DFSL_BST_HI] = fault.first_multihit |
                                    fault.second_multihit;
                rec[`DFSL_BST_LO] = fault.first_parity |
                                    fault.second_parity;
                if (any_buf_err) begin
                    if (fault.first_parity) begin
                        rec[`DFSL_SEL_HI:`DFSL_SEL_LO] = `DFSL_SEL_FIRST;
                        rec[`DFSL_IDX_HI:`DFSL_IDX_LO] = fault.first_index;
                    end else if (fault.second_parity) begin
                        rec[`DFSL_SEL_HI:`DFSL_SEL_LO] = `DFSL_SEL_SECOND;
                        rec[`DFSL_IDX_HI:`DFSL_IDX_LO] = fault.second_index;
                    end else if (fault.second_multihit) begin
                        rec[`DFSL_SEL_HI:`DFSL_SEL_LO] = `DFSL_SEL_SECOND;
                        rec[`DFSL_IDX_HI:`DFSL_IDX_LO] = fault.second_index;
                    end else begin
                        rec[`DFSL_SEL_HI:`DFSL_SEL_LO] = `DFSL_SEL_FIRST;
                        rec[`DFSL_IDX_HI:`DFSL_IDX_LO] = fault.first_index;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Bus slave and state update
    // ------------------------------------------------------------------
    logic        wr_go;
    logic        rd_go;
    logic [63:0] sw_val;
    logic [31:0] rd_val;
    logic [1:0]  rd_resp;
    logic [1:0]  wr_resp;

    assign s_axi_awready = !st_r.aw_ok && !st_r.bvalid;
    assign s_axi_wready  = !st_r.w_ok && !st_r.bvalid;
    assign s_axi_arready = !st_r.rvalid;

    always_comb begin
        st_nxt  = st_r;
        wr_go   = 1'b0;
        rd_go   = s_axi_arvalid && !st_r.rvalid;
        sw_val  = st_r.status;
        wr_resp = RESP_OKAY;
        rd_val  = 32'h0000_0000;
        rd_resp = RESP_OKAY;

        if (s_axi_awvalid && s_axi_awready) begin
            st_nxt.aw_ok  = 1'b1;
            st_nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_nxt.w_ok  = 1'b1;
            st_nxt.wdata = s_axi_wdata;
            st_nxt.wstrb = s_axi_wstrb;
        end
        wr_go = st_r.aw_ok && st_r.w_ok;
        if (wr_go) begin
            if (st_r.awaddr == `DFSL_OFF_STATUS_LO) begin
                sw_val[31:0] = lane_merge(st_r.status[31:0],
                                          st_r.wdata, st_r.wstrb);
            end else if (st_r.awaddr == `DFSL_OFF_STATUS_HI) begin
                sw_val[63:32] = lane_merge(st_r.status[63:32],
                                           st_r.wdata, st_r.wstrb);
            end else if (st_r.awaddr == `DFSL_OFF_CTRL) begin
                if (st_r.wstrb[0] && st_r.wdata[0]) begin
                    sw_val = `DFSL_RESET_VAL;
                end
            end else begin
                wr_resp = RESP_SLVERR;
            end
            st_nxt.aw_ok  = 1'b0;
            st_nxt.w_ok   = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp  = wr_resp;
        end
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end

        // A hardware capture in the same cycle outranks a software write.
        if (fault.kind != DFSL_EV_NONE) begin
            st_nxt.status = rec & `DFSL_DEF_MASK;
        end else begin
            st_nxt.status = sw_val & `DFSL_DEF_MASK;
        end

        if (rd_go) begin
            if (s_axi_araddr == `DFSL_OFF_STATUS_LO) begin
                rd_val = st_r.status[31:0];
            end else if (s_axi_araddr == `DFSL_OFF_STATUS_HI) begin
                rd_val = st_r.status[63:32];
            end else if (s_axi_araddr == `DFSL_OFF_CTRL) begin
                rd_val = 32'h0000_0000;
            end else begin
                rd_resp = RESP_SLVERR;
            end
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata  = rd_val;
            st_nxt.rresp  = rd_resp;
        end else if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign s_axi_bvalid      = st_r.bvalid;
    assign s_axi_bresp       = st_r.bresp;
    assign s_axi_rvalid      = st_r.rvalid;
    assign s_axi_rdata       = st_r.rdata;
    assign s_axi_rresp       = st_r.rresp;
    assign data_fault_status = st_r.status;

endmodule : dfsl_top

// [dfsl_map.svh]
/*
 * Offsets, field positions, reset values and fixed codes of the data fault
 * status log. Assumes inclusion by bare name from the design and the checker.
 */
`ifndef DFSL_MAP_SVH
`define DFSL_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses on the 32-bit bus)
// ----------------------------------------------------------------------
`define DFSL_OFF_STATUS_LO   8'h00
`define DFSL_OFF_STATUS_HI   8'h04
`define DFSL_OFF_CTRL        8'h08

// ----------------------------------------------------------------------
// Field positions of the 64-bit status record
// ----------------------------------------------------------------------
`define DFSL_SEL_HI          63
`define DFSL_SEL_LO          62
`define DFSL_IDX_HI          59
`define DFSL_IDX_LO          49
`define DFSL_MARK_BIT        46
`define DFSL_MARKID_HI       45
`define DFSL_MARKID_LO       32
`define DFSL_UNCORR_BIT      31
`define DFSL_BUSERR_BIT      30
`define DFSL_BUSTMO_BIT      29
`define DFSL_BST_HI          27
`define DFSL_BST_LO          26
`define DFSL_NC_BIT          25
`define DFSL_NOTRAP_BIT      24
`define DFSL_ASI_HI          23
`define DFSL_ASI_LO          16
`define DFSL_MISS_BIT        15
`define DFSL_FTYPE_HI        13
`define DFSL_FTYPE_LO        7
`define DFSL_E_BIT           6
`define DFSL_CTX_HI          5
`define DFSL_CTX_LO          4
`define DFSL_OVWR_BIT        1
`define DFSL_VALID_BIT       0

// Writable bit positions; all others read zero.
`define DFSL_DEF_MASK        64'hcffe_7fff_efff_bff3
`define DFSL_RESET_VAL       64'h0000_0000_0000_0000

// ----------------------------------------------------------------------
// Fixed codes
// ----------------------------------------------------------------------
`define DFSL_SEL_FIRST       2'h0
`define DFSL_SEL_SECOND      2'h2
`define DFSL_ASI_PRIMARY     8'h80
`define DFSL_ASI_PRIMARY_LE  8'h88
`define DFSL_ASI_NUCLEUS     8'h04
`define DFSL_ASI_NUCLEUS_LE  8'h0c
`define DFSL_ASI_SIDE_A      8'h15
`define DFSL_ASI_SIDE_B      8'h1d
`define DFSL_CTX_NONTRANS    2'h3

`endif

// [dfsl_pkg.sv]
/*
 * Types of the data fault status log.
 * Assumes dfsl_map.svh is reachable on the include path.
 */
package dfsl_pkg;

    typedef enum logic [1:0] {
        DFSL_EV_NONE  = 2'b00,
        DFSL_EV_MISS  = 2'b01,
        DFSL_EV_EXC   = 2'b10,
        DFSL_EV_ERR   = 2'b11
    } dfsl_ev_t;

    // One fault report from the data translation pipeline.
    typedef struct packed {
        dfsl_ev_t     kind;
        logic         first_parity;
        logic         second_parity;
        logic         second_multihit;
        logic         first_multihit;
        logic [10:0]  first_index;
        logic [10:0]  second_index;
        logic         uncorrectable;
        logic [13:0]  mark_id;
        logic         bus_error;
        logic         bus_timeout;
        logic         noncacheable;
        logic         no_trap_load;
        logic         asi_explicit;
        logic [7:0]   asi;
        logic         trap_level_nz;
        logic         current_little_endian;
        logic [6:0]   fault_type_code;
        logic         side_effect_page;
        logic [1:0]   context_type;
    } dfsl_fault_t;

    typedef struct packed {
        logic [63:0]  status;
        logic         aw_ok;
        logic [7:0]   awaddr;
        logic         w_ok;
        logic [31:0]  wdata;
        logic [3:0]   wstrb;
        logic         bvalid;
        logic [1:0]   bresp;
        logic         rvalid;
        logic [31:0]  rdata;
        logic [1:0]   rresp;
    } dfsl_state_t;

endpackage : dfsl_pkg

// [dfsl_top_props.sv]
/*
 * Checker for the data fault status log, watching only top-level ports.
 * Assumes one clock domain on aclk with a synchronous active-low reset.
 */
`timescale 1ns/1ps
`include "dfsl_map.svh"

module dfsl_props
    import dfsl_pkg::*;
(
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire dfsl_fault_t   fault,
    input  wire logic [1:0]    s_axi_bresp,
    input  wire logic          s_axi_bvalid,
    input  wire logic [63:0]   data_fault_status
);
    logic       ev;
    logic [1:0] bst;
    logic [7:0] imp;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    assign ev  = fault.kind inside {DFSL_EV_EXC, DFSL_EV_ERR};
    assign bst = {fault.first_multihit | fault.second_multihit,
                  fault.first_parity | fault.second_parity};
    assign imp = fault.trap_level_nz
               ? (fault.current_little_endian ? 8'h0c : 8'h04)
               : (fault.current_little_endian ? 8'h88 : 8'h80);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    chk_valid_set: assert property (ev |=> data_fault_status[0])
        else $error("fault valid not set after a fault");
    chk_overwrite_flag: assert property (
        ev && data_fault_status[0] |=> data_fault_status[1])
        else $error("overwrite flag not set");
    chk_mark_follows: assert property (
        fault.kind == DFSL_EV_ERR
        |=> data_fault_status[46] == data_fault_status[31])
        else $error("marked flag differs from uncorrectable flag");
    chk_uncorr_capture: assert property (
        fault.kind == DFSL_EV_ERR
        |=> data_fault_status[31] == $past(fault.uncorrectable))
        else $error("uncorrectable flag not captured");
    chk_miss_keeps: assert property (
        fault.kind == DFSL_EV_MISS
        |=> data_fault_status[15] && $stable(data_fault_status[0]))
        else $error("miss handling of miss flag or fault valid wrong");
    chk_type_capture: assert property (
        fault.kind == DFSL_EV_EXC
        |=> data_fault_status[13:7] == $past(fault.fault_type_code))
        else $error("fault type code not captured");
    chk_buf_status: assert property (
        fault.kind == DFSL_EV_ERR
        |=> data_fault_status[27:26] == $past(bst))
        else $error("buffer error status wrong");
    chk_implicit_asi: assert property (
        ev && !fault.asi_explicit |=> data_fault_status[23:16] == $past(imp))
        else $error("implicit identifier wrong");
    chk_undef_zero: assert property (
        (data_fault_status & ~`DFSL_DEF_MASK) == 64'h0)
        else $error("undefined status bit set");

    cov_overwrite: cover property (ev && data_fault_status[0]);
    cov_miss: cover property (fault.kind == DFSL_EV_MISS);
    cov_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule : dfsl_props

bind dfsl_top dfsl_props u_props (.aclk(aclk), .aresetn(aresetn),
    .fault(fault), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .data_fault_status(data_fault_status));

// [dfsl_top_test.sv]
/*
 * Self-checking bench for the data fault status log.
 * Assumes the register map at 0x00, 0x04 and clear control at 0x08.
 */
`timescale 1ns/1ps

module dfsl_top_test
    import dfsl_pkg::*;
;
    logic        aclk = 1'b0;
    logic        aresetn;
    dfsl_fault_t fault;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [2:0]  prot;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [1:0]  bresp, rresp;
    logic [63:0] status, got, exp;
    logic [7:0]  tab [4] = '{8'h80, 8'h88, 8'h04, 8'h0c};
    int          errors = 0;
    int          comparisons = 0;

    dfsl_top DUT (.aclk(aclk), .aresetn(aresetn), .fault(fault),
        .s_axi_awaddr(awaddr), .s_axi_awprot(prot), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(prot), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .data_fault_status(status));

    always #50 aclk = ~aclk;

    initial begin
        #400000;
        errors++;
        print_verdict();
    end

    // ------------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------------
    task cmp(input string what, input logic [63:0] e, input logic [63:0] g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask : cmp

    task send(input dfsl_fault_t f);
        @(posedge aclk);
        fault <= f;
        @(posedge aclk);
        fault <= '0;
        #1;
    endtask : send

    task axi_wr(input logic [7:0] a, input logic [31:0] d,
                input logic [3:0] s, output logic [1:0] r);
        logic done;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        done = 1'b0;
        for (int n = 0; n < 40 && !done; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                r = bresp;
                done = 1'b1;
                bready <= 1'b0;
            end
        end
        if (!done) errors++;
        #1;
    endtask : axi_wr

    task axi_rd(input logic [7:0] a, output logic [31:0] d,
                output logic [1:0] r);
        logic done;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        done = 1'b0;
        for (int n = 0; n < 40 && !done; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                r = rresp;
                done = 1'b1;
                rready <= 1'b0;
            end
        end
        if (!done) errors++;
        #1;
    endtask : axi_rd

    task rd64(output logic [63:0] v);
        logic [1:0] r;
        axi_rd(8'h00, v[31:0], r);
        axi_rd(8'h04, v[63:32], r);
    endtask : rd64

    task print_verdict();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        dfsl_fault_t f;
        logic [1:0]  r;
        aresetn = 1'b0;
        fault = '0;
        {awaddr, araddr, wdata, wstrb, prot} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd64(got);
        cmp("reset record", 64'h0, got);
        f = '{kind: DFSL_EV_ERR, first_parity: 1'b1, second_multihit: 1'b1,
              first_index: 11'h005, second_index: 11'h009,
              uncorrectable: 1'b1, mark_id: 14'h2abc, bus_error: 1'b1,
              bus_timeout: 1'b1,
              noncacheable: 1'b1, no_trap_load: 1'b1, asi_explicit: 1'b1,
              asi: 8'h15, context_type: 2'h1, fault_type_code: 7'h55,
              default: '0};
        send(f);
        cmp("error record", 64'h000a_6abc_ef15_0051, status);
        rd64(got);
        cmp("error by bus", 64'h000a_6abc_ef15_0051, got);
        f = '{kind: DFSL_EV_ERR, second_parity: 1'b1, first_multihit: 1'b1,
              first_index: 11'h003, second_index: 11'h7ff, bus_timeout: 1'b1,
              side_effect_page: 1'b1, trap_level_nz: 1'b1,
              current_little_endian: 1'b1, context_type: 2'h2, default: '0};
        send(f);
        cmp("overwrite", 64'h8ffe_0000_2c0c_0063, status);
        $display("test error capture finished");
        axi_wr(8'h08, 32'h1, 4'hf, r);
        cmp("clear", 64'h0, status);
        cmp("clear response", 64'h0, {62'h0, r});
        axi_wr(8'h00, 32'hffff_ffff, 4'hf, r);
        axi_wr(8'h04, 32'hffff_ffff, 4'hf, r);
        axi_wr(8'h00, 32'h0, 4'h1, r);
        axi_wr(8'h0c, 32'h0, 4'hf, r);
        cmp("unmapped write", 64'h2, {62'h0, r});
        rd64(got);
        cmp("masked", 64'hcffe_7fff_efff_bf00, got);
        axi_rd(8'h0c, got[31:0], r);
        cmp("unmapped read", 64'h2_0000_0000, {30'h0, r, got[31:0]});
        axi_wr(8'h08, 32'h1, 4'hf, r);
        $display("test registers finished");
        for (int i = 0; i < 4; i++) begin
            f = '{kind: DFSL_EV_EXC, trap_level_nz: i[1], no_trap_load: i[0],
                  current_little_endian: i[0], fault_type_code: 7'(1 << i),
                  context_type: 2'(i), uncorrectable: 1'b1, default: '0};
            send(f);
            exp = 64'h1 | (64'(i > 0) << 1) | (64'(i) << 4) |
                  (64'(1 << i) << 7) | (64'(tab[i]) << 16) | (64'(i & 1) << 24);
            cmp("exception", exp, status);
        end
        $display("test exceptions finished");
        f = '{kind: DFSL_EV_MISS, asi_explicit: 1'b1, asi: 8'h33,
              context_type: 2'h3, default: '0};
        send(f);
        cmp("miss kept", exp | 64'h8000, status);
        axi_wr(8'h08, 32'h1, 4'hf, r);
        send(f);
        cmp("fresh miss", 64'h0000_0000_0033_8030, status);
        $display("test misses finished");
        print_verdict();
    end
endmodule : dfsl_top_test
